/* File: lcv_pkg.sv */
/*
 * Shared constants for the loop compensation and regulator select bank:
 * command codes, field positions, reset values, state encoding, timing.
 * Assumes a 100 MHz system clock and a byte-level PMBus link layer.
 */
package lcv_pkg;
    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_COMP = 8'hB1;
    localparam logic [7:0] CMD_REGSEL = 8'hB5;
    localparam logic [7:0] CMD_DEV_ID = 8'hAD;
    localparam logic [7:0] CMD_DEV_REV = 8'hAE;
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;

    // ------------------------------------------------------------------
    // Payload sizes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] COMP_BYTES = 3'h5;
    localparam logic [2:0] REGSEL_BYTES = 3'h1;
    localparam logic [2:0] IDX_SAT = 3'h7;
    localparam logic [39:0] COMP_RESET = 40'h00_0000_0000;
    localparam logic [3:0] REGSEL_RESET = 4'h0;
    localparam logic [3:0] REGSEL_LOW_NIBBLE = 4'h0;
    localparam logic [3:0] REG_CODE_MIN = 4'h3;
    localparam logic [3:0] REG_CODE_MAX = 4'hA;

    // ------------------------------------------------------------------
    // Compensation word field positions (low bit of each field)
    // ------------------------------------------------------------------
    localparam int CUR_TRANSCOND_LSB = 0;
    localparam int VOLT_TRANSCOND_LSB = 4;
    localparam int VOLT_INTEG_HI_LSB = 8;
    localparam int VOLT_GAIN_RES_LSB = 10;
    localparam int VOLT_FILTER_CAP_LSB = 17;
    localparam int VOLT_INTEG_LO_LSB = 22;
    localparam int CUR_INTEG_HI_LSB = 24;
    localparam int CUR_GAIN_RES_LSB = 26;
    localparam int CUR_DOUBLER_BIT = 32;
    localparam int CUR_FILTER_CAP_LSB = 33;
    localparam int CUR_INTEG_LO_LSB = 38;
    localparam int REGSEL_CODE_LSB = 4;

    // ------------------------------------------------------------------
    // Timing: longest transaction time
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int MAX_XFER_US = 1000;
    localparam int MAX_XFER_CYCLES = MAX_XFER_US * CLK_MHZ;
    localparam int TCNT_W = 17;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_ACTIVE = 2'b01,
        XF_ABORT = 2'b10
    } lcv_xfer_e;
endpackage : lcv_pkg

/* File: lcv_comp_fields.sv */
/*
 * Splits the applied compensation word into the analogue selection codes
 * and range-checks the regulator select code.
 * Assumes its inputs come from flip-flops in the same clock domain.
 */
`timescale 1ns/1ns
module lcv_comp_fields
    import lcv_pkg::*;
(
    input wire logic [39:0] comp_word,
    input wire logic [3:0] reg_code,
    output logic [3:0] cur_integ_cap_code,
    output logic cur_integ_cap_doubler,
    output logic [4:0] cur_filter_cap_code,
    output logic [5:0] cur_gain_res_code,
    output logic [3:0] volt_integ_cap_code,
    output logic [4:0] volt_filter_cap_code,
    output logic [5:0] volt_gain_res_code,
    output logic [1:0] volt_transcond_code,
    output logic [1:0] cur_transcond_code,
    output logic reg_code_ok
);
    // ------------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------------
    // Current integrator code halves
    assign cur_integ_cap_code = {comp_word[CUR_INTEG_HI_LSB +: 2],
                                 comp_word[CUR_INTEG_LO_LSB +: 2]};
    assign cur_integ_cap_doubler = comp_word[CUR_DOUBLER_BIT];
    assign cur_filter_cap_code = comp_word[CUR_FILTER_CAP_LSB +: 5];
    assign cur_gain_res_code = comp_word[CUR_GAIN_RES_LSB +: 6];
    assign volt_integ_cap_code = {comp_word[VOLT_INTEG_HI_LSB +: 2],
                                  comp_word[VOLT_INTEG_LO_LSB +: 2]};
    assign volt_filter_cap_code = comp_word[VOLT_FILTER_CAP_LSB +: 5];
    assign volt_gain_res_code = comp_word[VOLT_GAIN_RES_LSB +: 6];
    assign volt_transcond_code = comp_word[VOLT_TRANSCOND_LSB +: 2];
    assign cur_transcond_code = comp_word[CUR_TRANSCOND_LSB +: 2];
    assign reg_code_ok = (reg_code >= REG_CODE_MIN) &&
                         (reg_code <= REG_CODE_MAX);
endmodule : lcv_comp_fields

/* File: lcv_bank.sv */
/*
 * Compensation word and regulator select register bank behind PMBus
 * block read and block write commands.
 * Assumes a byte-level link layer on the same clock that marks the
 * command code, each written byte, each read byte request and the stop.
 */
// Operation
// - Compensation payload five bytes, block read/write
// - Apply now if off, else store only
// - Current integrator code from 25:24, 39:38
// - Bit 32 doubles current integrator cap
// - Bits 37:33 current filter cap code
// - Bits 31:26 current gain resistor code
// - Voltage integrator code from 9:8, 23:22
// - Bits 21:17 voltage filter cap code
// - Bits 15:10 voltage gain resistor code
// - Bits 5:4 voltage transconductance code
// - Bits 1:0 current transconductance code
// - Regulator payload one byte, block transfers
// - Regulator setting applies on the fly
// - Low nibble reads as zero
// - Defaults from memory or straps; regulator memory
// - Write to read-only command flags fault
`timescale 1ns/1ns
module lcv_bank
    import lcv_pkg::*;
#(
    parameter int XFER_LIMIT_CYCLES = MAX_XFER_CYCLES
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CMD_START,
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_BYTE_VALID,
    input wire logic [7:0] WR_BYTE,
    input wire logic RD_BYTE_REQ,
    input wire logic XFER_END,
    output logic [7:0] RD_BYTE,
    output logic RD_BYTE_VALID,
    input wire logic CONV_ENABLE,
    input wire logic DEFAULT_LOAD,
    input wire logic COMP_USE_STRAP,
    input wire logic [39:0] NVM_COMP,
    input wire logic [39:0] STRAP_COMP,
    input wire logic [7:0] NVM_REGSEL,
    input wire logic CLEAR_FAULTS,
    output logic BAD_COMMAND_FLAG,
    output logic HOST_ALERT_B,
    output logic COMP_PENDING,
    output logic [3:0] CUR_INTEG_CAP_CODE,
    output logic CUR_INTEG_CAP_DOUBLER,
    output logic [4:0] CUR_FILTER_CAP_CODE,
    output logic [5:0] CUR_GAIN_RES_CODE,
    output logic [3:0] VOLT_INTEG_CAP_CODE,
    output logic [4:0] VOLT_FILTER_CAP_CODE,
    output logic [5:0] VOLT_GAIN_RES_CODE,
    output logic [1:0] VOLT_TRANSCOND_CODE,
    output logic [1:0] CUR_TRANSCOND_CODE,
    output logic [3:0] REGULATOR_TARGET_CODE,
    output logic REGULATOR_CODE_VALID
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_read_only(input logic [7:0] code);
        is_read_only = (code == CMD_DEV_ID) || (code == CMD_DEV_REV);
    endfunction : is_read_only
    function automatic logic [7:0] pick_byte(input logic [39:0] word,
                                             input logic [2:0] num);
        pick_byte = (num <= 3'h4) ? word[8*num +: 8] : 8'h00;
    endfunction : pick_byte
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lcv_xfer_e state, next_state;
    logic [7:0] cmd, next_cmd;
    logic [2:0] wr_idx, next_wr_idx;
    logic [2:0] rd_idx, next_rd_idx;
    logic [7:0] wr_count, next_wr_count;
    logic [39:0] wbuf, next_wbuf;
    logic [39:0] comp_store, next_comp_store;
    logic [39:0] comp_applied, next_comp_applied;
    logic pending, next_pending;
    logic [3:0] regsel, next_regsel;
    logic bad_flag, next_bad_flag;
    logic [7:0] rd_byte, next_rd_byte;
    logic rd_valid, next_rd_valid;
    logic rd_data, next_rd_data;
    logic [TCNT_W-1:0] tcnt, next_tcnt;
    logic commit_comp, commit_reg, write_ok;
    logic [2:0] expect_bytes;
    logic [39:0] dflt_comp;
    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_wr_count = wr_count;
        next_wbuf = wbuf;
        next_comp_store = comp_store;
        next_comp_applied = comp_applied;
        next_pending = pending;
        next_regsel = regsel;
        next_bad_flag = bad_flag;
        next_rd_byte = rd_byte;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        next_tcnt = tcnt;
        commit_comp = 1'b0;
        commit_reg = 1'b0;
        expect_bytes = (cmd == CMD_COMP) ? COMP_BYTES : REGSEL_BYTES;
        // Count byte plus exact payload length
        write_ok = (wr_idx != 3'h0) &&
                   (wr_count == {5'h00, expect_bytes}) &&
                   (wr_idx == expect_bytes + 3'h1);
        dflt_comp = COMP_USE_STRAP ? STRAP_COMP : NVM_COMP;
        // Fault clear loses to a new fault
        if (CLEAR_FAULTS) begin
            next_bad_flag = 1'b0;
        end
        case (state)
            XF_IDLE: begin
                if (CMD_START) begin
                    next_state = XF_ACTIVE;
                    next_cmd = CMD_CODE;
                    next_wr_idx = 3'h0;
                    next_rd_idx = 3'h0;
                    next_rd_data = 1'b0;
                    next_tcnt = '0;
                end
            end
            XF_ACTIVE: begin
                next_tcnt = tcnt + 1'b1;
                if (XFER_END) begin
                    next_state = XF_IDLE;
                    commit_comp = write_ok && (cmd == CMD_COMP);
                    commit_reg = write_ok && (cmd == CMD_REGSEL);
                end else if (tcnt == TCNT_W'(XFER_LIMIT_CYCLES - 1)) begin
                    next_state = XF_ABORT;
                end else if (WR_BYTE_VALID) begin
                    if (is_read_only(cmd)) begin
                        next_bad_flag = 1'b1;
                    end
                    if (wr_idx == 3'h0) begin
                        next_wr_count = WR_BYTE;
                    end else if (wr_idx <= COMP_BYTES) begin
                        next_wbuf[8*(wr_idx-3'h1) +: 8] = WR_BYTE;
                    end
                    if (wr_idx != IDX_SAT) begin
                        next_wr_idx = wr_idx + 3'h1;
                    end
                end else if (RD_BYTE_REQ) begin
                    next_rd_valid = 1'b1;
                    next_rd_data = (rd_idx != 3'h0);
                    if (rd_idx != IDX_SAT) begin
                        next_rd_idx = rd_idx + 3'h1;
                    end
                    // Block read: count then bytes, low first
                    if (cmd == CMD_COMP) begin
                        next_rd_byte = (rd_idx == 3'h0) ?
                            {5'h00, COMP_BYTES} :
                            pick_byte(comp_store, rd_idx - 3'h1);
                    end else if (cmd == CMD_REGSEL) begin
                        next_rd_byte = (rd_idx == 3'h0) ?
                            {5'h00, REGSEL_BYTES} :
                            (rd_idx == 3'h1) ?
                            {regsel, REGSEL_LOW_NIBBLE} : 8'h00;
                    end else begin
                        next_rd_byte = 8'h00;
                    end
                end
            end
            XF_ABORT: begin
                if (XFER_END) begin
                    next_state = XF_IDLE;
                end
            end
            default: begin
                next_state = XF_IDLE;
            end
        endcase
        if (DEFAULT_LOAD) begin
            // Defaults reach store and loop together
            next_comp_store = dflt_comp;
            next_comp_applied = dflt_comp;
            next_pending = 1'b0;
            next_regsel = NVM_REGSEL[REGSEL_CODE_LSB +: 4];
        end else begin
            if (commit_comp) begin
                // Store always keeps the written word
                next_comp_store = wbuf;
                // Forward only while conversion is off
                if (CONV_ENABLE) begin
                    next_pending = 1'b1;
                end else begin
                    next_comp_applied = wbuf;
                    next_pending = 1'b0;
                end
            end
            // Regulator code takes effect on the fly
            if (commit_reg) begin
                next_regsel = wbuf[REGSEL_CODE_LSB +: 4];
            end
        end
    end
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state <= XF_IDLE;
            cmd <= 8'h00;
            wr_idx <= 3'h0;
            rd_idx <= 3'h0;
            wr_count <= 8'h00;
            wbuf <= COMP_RESET;
            comp_store <= COMP_RESET;
            comp_applied <= COMP_RESET;
            pending <= 1'b0;
            regsel <= REGSEL_RESET;
            bad_flag <= 1'b0;
            rd_byte <= 8'h00;
            rd_valid <= 1'b0;
            rd_data <= 1'b0;
            tcnt <= '0;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            wr_count <= next_wr_count;
            wbuf <= next_wbuf;
            comp_store <= next_comp_store;
            comp_applied <= next_comp_applied;
            pending <= next_pending;
            regsel <= next_regsel;
            bad_flag <= next_bad_flag;
            rd_byte <= next_rd_byte;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            tcnt <= next_tcnt;
        end
    end
    assign RD_BYTE = rd_byte;
    assign RD_BYTE_VALID = rd_valid;
    assign BAD_COMMAND_FLAG = bad_flag;
    assign HOST_ALERT_B = ~bad_flag;
    assign COMP_PENDING = pending;
    assign REGULATOR_TARGET_CODE = regsel;
    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    lcv_comp_fields lcv_comp_fields_i (
        .comp_word(comp_applied),
        .reg_code(regsel),
        .cur_integ_cap_code(CUR_INTEG_CAP_CODE),
        .cur_integ_cap_doubler(CUR_INTEG_CAP_DOUBLER),
        .cur_filter_cap_code(CUR_FILTER_CAP_CODE),
        .cur_gain_res_code(CUR_GAIN_RES_CODE),
        .volt_integ_cap_code(VOLT_INTEG_CAP_CODE),
        .volt_filter_cap_code(VOLT_FILTER_CAP_CODE),
        .volt_gain_res_code(VOLT_GAIN_RES_CODE),
        .volt_transcond_code(VOLT_TRANSCOND_CODE),
        .cur_transcond_code(CUR_TRANSCOND_CODE),
        .reg_code_ok(REGULATOR_CODE_VALID)
    );
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    comp_apply_off_a: assert property (
        commit_comp && !CONV_ENABLE && !DEFAULT_LOAD |=>
        comp_applied == $past(wbuf) && !COMP_PENDING)
        else $error("compensation not applied while off");
    comp_hold_on_a: assert property (
        commit_comp && CONV_ENABLE && !DEFAULT_LOAD |=>
        $stable(comp_applied) && COMP_PENDING)
        else $error("compensation reached loop while on");
    comp_readback_a: assert property (
        commit_comp && !DEFAULT_LOAD |=> comp_store == $past(wbuf))
        else $error("stored compensation differs from write");
    cur_field_map_a: assert property (
        ##1 $changed(comp_applied) |->
        CUR_INTEG_CAP_CODE == {comp_applied[25:24], comp_applied[39:38]} &&
        CUR_INTEG_CAP_DOUBLER == comp_applied[32] &&
        CUR_FILTER_CAP_CODE == comp_applied[37:33] &&
        CUR_GAIN_RES_CODE == comp_applied[31:26] &&
        CUR_TRANSCOND_CODE == comp_applied[1:0])
        else $error("current loop field map wrong");
    volt_field_map_a: assert property (
        VOLT_INTEG_CAP_CODE == {comp_applied[9:8], comp_applied[23:22]} &&
        VOLT_FILTER_CAP_CODE == comp_applied[21:17] &&
        VOLT_GAIN_RES_CODE == comp_applied[15:10] &&
        VOLT_TRANSCOND_CODE == comp_applied[5:4])
        else $error("voltage loop field map wrong");
    regsel_fly_a: assert property (
        state == XF_ACTIVE && XFER_END && cmd == CMD_REGSEL && write_ok &&
        !DEFAULT_LOAD |-> ##1 REGULATOR_TARGET_CODE == $past(wbuf[7:4]))
        else $error("regulator code not updated on the fly");
    reg_code_range_a: assert property (
        REGULATOR_CODE_VALID == (REGULATOR_TARGET_CODE inside {[4'h3:4'hA]}))
        else $error("regulator code range flag wrong");
    reg_low_zero_a: assert property (
        RD_BYTE_VALID && rd_data && cmd == CMD_REGSEL |->
        RD_BYTE[3:0] == 4'h0)
        else $error("reserved nibble read nonzero");
    count_byte_a: assert property (
        RD_BYTE_VALID && !rd_data |->
        (cmd == CMD_COMP && RD_BYTE == 8'h05) ||
        (cmd == CMD_REGSEL && RD_BYTE == 8'h01) ||
        (cmd != CMD_COMP && cmd != CMD_REGSEL))
        else $error("block read count byte wrong");
    bad_cmd_a: assert property (
        state == XF_ACTIVE && !XFER_END && WR_BYTE_VALID &&
        is_read_only(cmd) && tcnt != TCNT_W'(XFER_LIMIT_CYCLES - 1) |=>
        BAD_COMMAND_FLAG && !HOST_ALERT_B)
        else $error("read-only write not flagged");
    default_load_a: assert property (
        DEFAULT_LOAD |=> comp_store == $past(dflt_comp) &&
        comp_applied == comp_store && regsel == $past(NVM_REGSEL[7:4]))
        else $error("default load wrong");
endmodule : lcv_bank

/* File: lcv_host.sv */
/*
 * Host model for the bank: block writes and block reads over the
 * byte link. Assumes the bench calls its tasks; drives at falling edge.
 */
`timescale 1ns/1ns
module lcv_host (
    input wire logic clk,
    output logic cmd_start,
    output logic [7:0] cmd_code,
    output logic wr_valid,
    output logic [7:0] wr_byte,
    output logic rd_req,
    output logic xfer_end,
    input wire logic [7:0] rd_byte,
    input wire logic rd_valid
);
    initial begin
        {cmd_start, wr_valid, rd_req, xfer_end} = 4'h0;
        cmd_code = 8'h00;
        wr_byte = 8'h00;
    end
    // Count then n bytes, low byte first
    task automatic blk_write(input logic [7:0] code, input logic [7:0] cnt,
                             input int n, input logic [39:0] data);
        @(negedge clk);
        cmd_start = 1'b1;
        cmd_code = code;
        @(negedge clk);
        cmd_start = 1'b0;
        wr_valid = 1'b1;
        wr_byte = cnt;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            wr_byte = data[8*i +: 8];
        end
        @(negedge clk);
        wr_valid = 1'b0;
        wr_byte = ~wr_byte;
        xfer_end = 1'b1;
        @(negedge clk);
        xfer_end = 1'b0;
    endtask : blk_write
    // Count byte first, then data bytes
    task automatic blk_read(input logic [7:0] code, input int n,
                            output logic [47:0] data);
        data = 48'h0;
        @(negedge clk);
        cmd_start = 1'b1;
        cmd_code = code;
        @(negedge clk);
        cmd_start = 1'b0;
        for (int i = 0; i <= n; i++) begin
            rd_req = 1'b1;
            @(negedge clk);
            rd_req = 1'b0;
            data[8*i +: 8] = (rd_valid === 1'b1) ? rd_byte : 8'hEE;
            @(negedge clk);
        end
        xfer_end = 1'b1;
        @(negedge clk);
        xfer_end = 1'b0;
    endtask : blk_read
    // Count, idle gap, one byte, stop
    task automatic blk_stall(input logic [7:0] code, input int gap,
                             input logic [7:0] dat);
        @(negedge clk);
        cmd_start = 1'b1;
        cmd_code = code;
        @(negedge clk);
        cmd_start = 1'b0;
        wr_valid = 1'b1;
        wr_byte = 8'h01;
        repeat (gap) begin
            @(negedge clk);
            wr_valid = 1'b0;
        end
        @(negedge clk);
        wr_valid = 1'b1;
        wr_byte = dat;
        @(negedge clk);
        wr_valid = 1'b0;
        xfer_end = 1'b1;
        @(negedge clk);
        xfer_end = 1'b0;
    endtask : blk_stall
endmodule : lcv_host

/* File: lcv_bank_bench.sv */
/*
 * Self-checking bench for the compensation and regulator bank.
 * Assumes lcv_pkg, lcv_bank and the lcv_host model are compiled first.
 */
`timescale 1ns/1ns
module lcv_bank_bench;
    import lcv_pkg::*;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic CMD_START, WR_BYTE_VALID, RD_BYTE_REQ, XFER_END, RD_BYTE_VALID;
    logic [7:0] CMD_CODE, WR_BYTE, RD_BYTE;
    logic CONV_ENABLE = 1'b0;
    logic DEFAULT_LOAD = 1'b0;
    logic COMP_USE_STRAP = 1'b0;
    logic CLEAR_FAULTS = 1'b0;
    logic [39:0] NVM_COMP = 40'h0;
    logic [39:0] STRAP_COMP = 40'h0;
    logic [7:0] NVM_REGSEL = 8'h00;
    logic BAD_COMMAND_FLAG, HOST_ALERT_B, COMP_PENDING, REGULATOR_CODE_VALID;
    logic [3:0] REGULATOR_TARGET_CODE;
    wire [34:0] flds;
    logic [47:0] rd;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam logic [39:0] P1 = 40'hA53C96F003;
    localparam logic [39:0] P2 = 40'h5AC3680F30;
    always #5 CLK = ~CLK;
    lcv_bank #(.XFER_LIMIT_CYCLES(64)) lcv_bank_i (.CLK(CLK), .RST_B(RST_B),
        .CMD_START(CMD_START), .CMD_CODE(CMD_CODE),
        .WR_BYTE_VALID(WR_BYTE_VALID), .WR_BYTE(WR_BYTE),
        .RD_BYTE_REQ(RD_BYTE_REQ), .XFER_END(XFER_END), .RD_BYTE(RD_BYTE),
        .RD_BYTE_VALID(RD_BYTE_VALID), .CONV_ENABLE(CONV_ENABLE),
        .DEFAULT_LOAD(DEFAULT_LOAD), .COMP_USE_STRAP(COMP_USE_STRAP),
        .NVM_COMP(NVM_COMP), .STRAP_COMP(STRAP_COMP), .NVM_REGSEL(NVM_REGSEL),
        .CLEAR_FAULTS(CLEAR_FAULTS), .BAD_COMMAND_FLAG(BAD_COMMAND_FLAG),
        .HOST_ALERT_B(HOST_ALERT_B), .COMP_PENDING(COMP_PENDING),
        .CUR_INTEG_CAP_CODE(flds[34:31]), .CUR_INTEG_CAP_DOUBLER(flds[30]),
        .CUR_FILTER_CAP_CODE(flds[29:25]), .CUR_GAIN_RES_CODE(flds[24:19]),
        .VOLT_INTEG_CAP_CODE(flds[18:15]), .VOLT_FILTER_CAP_CODE(flds[14:10]),
        .VOLT_GAIN_RES_CODE(flds[9:4]), .VOLT_TRANSCOND_CODE(flds[3:2]),
        .CUR_TRANSCOND_CODE(flds[1:0]),
        .REGULATOR_TARGET_CODE(REGULATOR_TARGET_CODE),
        .REGULATOR_CODE_VALID(REGULATOR_CODE_VALID));
    lcv_host lcv_host_i (.clk(CLK), .cmd_start(CMD_START), .cmd_code(CMD_CODE),
        .wr_valid(WR_BYTE_VALID), .wr_byte(WR_BYTE), .rd_req(RD_BYTE_REQ),
        .xfer_end(XFER_END), .rd_byte(RD_BYTE), .rd_valid(RD_BYTE_VALID));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Field split
    function automatic logic [34:0] fld(input logic [39:0] w);
        return {w[25:24], w[39:38], w[32], w[37:33], w[31:26], w[9:8],
                w[23:22], w[21:17], w[15:10], w[5:4], w[1:0]};
    endfunction : fld
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse_load(input logic strap);
        @(negedge CLK);
        COMP_USE_STRAP = strap;
        DEFAULT_LOAD = 1'b1;
        @(negedge CLK);
        DEFAULT_LOAD = 1'b0;
        @(negedge CLK);
    endtask : pulse_load
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults;
        NVM_COMP = P1;
        STRAP_COMP = P2;
        NVM_REGSEL = 8'h7C;
        pulse_load(1'b0);
        chk(flds, fld(P1));
        chk({REGULATOR_TARGET_CODE, REGULATOR_CODE_VALID}, 5'h0F);
        pulse_load(1'b1);
        chk({flds, REGULATOR_TARGET_CODE}, {fld(P2), 4'h7});
    endtask : t_defaults
    task automatic t_comp;
        lcv_host_i.blk_write(CMD_COMP, 8'h05, 5, P1);
        @(negedge CLK);
        chk({COMP_PENDING, flds}, {1'b0, fld(P1)});
        CONV_ENABLE = 1'b1;
        lcv_host_i.blk_write(CMD_COMP, 8'h05, 5, P2);
        @(negedge CLK);
        chk({COMP_PENDING, flds}, {1'b1, fld(P1)});
        lcv_host_i.blk_read(CMD_COMP, 5, rd);
        chk(rd, {P2, 8'h05});
        lcv_host_i.blk_write(CMD_COMP, 8'h05, 4, P1);
        lcv_host_i.blk_read(CMD_COMP, 5, rd);
        chk(rd, {P2, 8'h05});
        NVM_COMP = P2;
        pulse_load(1'b0);
        chk({COMP_PENDING, flds}, {1'b0, fld(P2)});
        CONV_ENABLE = 1'b0;
    endtask : t_comp
    task automatic t_regsel;
        logic [3:0] c;
        // All 16 codes 0h-Fh tried; bench stands in for outside supply
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            lcv_host_i.blk_write(CMD_REGSEL, 8'h01, 1, {36'h0, c});
            @(negedge CLK);
            chk(REGULATOR_TARGET_CODE, 4'h0);
            lcv_host_i.blk_write(CMD_REGSEL, 8'h01, 1, {32'h0, c, 4'hF});
            @(negedge CLK);
            chk(REGULATOR_TARGET_CODE, c);
            chk(REGULATOR_CODE_VALID, c >= 4'h3 && c <= 4'hA);
            lcv_host_i.blk_read(CMD_REGSEL, 1, rd);
            chk(rd[15:0], {c, 4'h0, 8'h01});
        end
    endtask : t_regsel
    task automatic t_abort;
        lcv_host_i.blk_stall(CMD_REGSEL, 0, 8'h9F);
        @(negedge CLK);
        chk(REGULATOR_TARGET_CODE, 4'h9);
        lcv_host_i.blk_stall(CMD_REGSEL, 70, 8'h5F);
        @(negedge CLK);
        chk(REGULATOR_TARGET_CODE, 4'h9);
    endtask : t_abort
    task automatic t_fault;
        lcv_host_i.blk_read(CMD_DEV_REV, 1, rd);
        chk({rd[15:0], BAD_COMMAND_FLAG}, 17'h0);
        lcv_host_i.blk_write(CMD_DEV_ID, 8'h01, 1, 40'h5A);
        @(negedge CLK);
        chk({BAD_COMMAND_FLAG, HOST_ALERT_B}, 2'b10);
        CLEAR_FAULTS = 1'b1;
        @(negedge CLK);
        CLEAR_FAULTS = 1'b0;
        @(negedge CLK);
        chk({BAD_COMMAND_FLAG, HOST_ALERT_B}, 2'b01);
        lcv_host_i.blk_write(CMD_DEV_REV, 8'h01, 1, 40'h5A);
        @(negedge CLK);
        chk({BAD_COMMAND_FLAG, HOST_ALERT_B}, 2'b10);
    endtask : t_fault
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(negedge CLK);
        RST_B = 1'b1;
        @(negedge CLK);
        chk({flds, HOST_ALERT_B}, {35'h0, 1'b1});
        t_defaults();
        t_comp();
        t_regsel();
        t_abort();
        t_fault();
        tally_and_finish();
    end
endmodule : lcv_bank_bench
